// ---- design/tpl_cfg.svh ----
// Purpose: offsets, bit positions and reset values of the phase-level block
// Assumes: byte addresses on a 32-bit classic Wishbone slave
// Notes: definitions only
`ifndef TPL_CFG_SVH
`define TPL_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TPL_ADR_START 8'h00
`define TPL_ADR_INVC_FIRST 8'h04
`define TPL_ADR_INVC_SECOND 8'h08
`define TPL_ADR_BUF_FIRST 8'h0c
`define TPL_ADR_BUF_SECOND 8'h10
`define TPL_ADR_CARRIER 8'h14
`define TPL_ADR_WIDTH_U 8'h18
`define TPL_ADR_WIDTH_V 8'h1c
`define TPL_ADR_WIDTH_W 8'h20
`define TPL_ADR_DEAD 8'h24
`define TPL_ADR_STATUS 8'h28
`define TPL_ADR_PH_MODE 8'h2c
`define TPL_ADR_CAR_MODE 8'h30
`define TPL_ADR_TRIG_SEL 8'h34

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TPL_BIT_V_START 1
`define TPL_BIT_W_START 2
`define TPL_BIT_U_START 4
`define TPL_BIT_CAR_START 7
`define TPL_BIT_SW_TRANSFER 7
`define TPL_BIT_CAR_STOP 0
`define TPL_BIT_DT_DISABLE 5
`define TPL_TRG_V_LSB 0
`define TPL_TRG_W_LSB 2
`define TPL_TRG_U_LSB 6
`define TPL_TRG_ONESHOT 2'b01

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define TPL_RST_BYTE 8'h00
`define TPL_RST_HALF 16'h0000
`define TPL_RST_LEVEL 6'h00
`define TPL_RST_WORD 32'h00000000
`define TPL_RST_DEAD 8'h01
`define TPL_HALF_ONE 16'h0001
`define TPL_BYTE_ONE 8'h01

`endif

// ---- design/tpl_oneshot.sv ----
// Purpose: one phase one-shot timer, pulse high while counting down
// Assumes: start is a one-cycle pulse on mclk
// Notes: a start while counting restarts the count
`timescale 1ns/1ps
`default_nettype none
`include "tpl_cfg.svh"

module tpl_oneshot (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control
  input wire logic startPulse,
  input wire logic runEn,
  input wire tpl_pkg::tpl_count_t widthVal,
  // pulse
  output logic pulseOut,
  output logic fallPulse
);
  import tpl_pkg::*;

  tpl_os_state_t state_reg;
  tpl_count_t cnt_reg;

  // load on start, count to one, then drop the pulse
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= TPL_OS_IDLE;
      cnt_reg <= `TPL_RST_HALF;
      pulseOut <= 1'b0;
      fallPulse <= 1'b0;
    end else begin
      fallPulse <= 1'b0;
      case (state_reg)
        TPL_OS_IDLE: begin
          if (startPulse && runEn && widthVal != `TPL_RST_HALF) begin
            state_reg <= TPL_OS_COUNT;
            cnt_reg <= widthVal;
            pulseOut <= 1'b1;
          end
        end
        TPL_OS_COUNT: begin
          if (!runEn) begin
            // stopping mid-pulse ends it with no falling-edge event
            state_reg <= TPL_OS_IDLE;
            pulseOut <= 1'b0;
          end else if (startPulse && widthVal != `TPL_RST_HALF) begin
            cnt_reg <= widthVal;
          end else if (cnt_reg == `TPL_HALF_ONE) begin
            state_reg <= TPL_OS_IDLE;
            pulseOut <= 1'b0;
            fallPulse <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - `TPL_HALF_ONE;
          end
        end
        default: begin
          state_reg <= TPL_OS_IDLE;
          pulseOut <= 1'b0;
        end
      endcase
    end
  end
endmodule : tpl_oneshot
`default_nettype wire

// ---- design/tpl_pkg.sv ----
// Purpose: shared types of the phase-level block
// Assumes: nothing beyond the cfg header
// Notes: types only, constants live in tpl_cfg.svh
package tpl_pkg;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [15:0] tpl_count_t;
  typedef logic [7:0] tpl_byte_t;
  typedef logic [5:0] tpl_level_t;
  typedef enum logic {TPL_OS_IDLE, TPL_OS_COUNT} tpl_os_state_t;
endpackage : tpl_pkg

// ---- design/tpl_pwm_top.sv ----
// Purpose: three-phase output level control, triangular modulation mode 0
// Assumes: classic Wishbone slave, one clock mclk, async reset sys_rst
// Notes: outputs bits 0..2 are U,V,W upper, bits 3..5 U,V,W lower arms
`timescale 1ns/1ps
`default_nettype none
`include "tpl_cfg.svh"

// Behaviour
// - common start trigger loads each phase one-shot with its width value
// - transfer trigger copies both level buffers into phase shift registers
// - after transfer phase takes first buffer, then second at pulse fall
// - phase keeps alternating between both buffers at every pulse fall
// - with dead time on, active-to-inactive follows internal signal at once
// - with dead time on, inactive-to-active waits for dead timer to stop
// - first carrier underflow after both buffers written makes a transfer
// - writing carrier reload while carrier stop bit is 1 makes a transfer
// - writing 1 to the software transfer bit makes a transfer
module tpl_pwm_top (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire tpl_pkg::tpl_byte_t adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // gate driver outputs
  output tpl_pkg::tpl_level_t pwmOut
);
  import tpl_pkg::*;
  default clocking cbMain @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  tpl_byte_t countStart_reg;
  tpl_byte_t invFirst_reg;
  tpl_byte_t invSecond_reg;
  tpl_level_t levelBufFirst_reg;
  tpl_level_t levelBufSecond_reg;
  tpl_count_t carrierReload_reg;
  tpl_count_t phWidth_reg [3];
  tpl_byte_t deadTime_reg;
  tpl_byte_t phMode_reg;
  tpl_byte_t carMode_reg;
  tpl_byte_t trigSel_reg;
  logic wroteFirst_reg;
  logic wroteSecond_reg;
  tpl_count_t carrierCnt_reg;
  tpl_level_t stageFirst_reg;
  tpl_level_t stageSecond_reg;
  tpl_level_t internal_reg;
  logic [2:0] selSecond_reg;
  logic [31:0] rdData_next;

  logic wrEn;
  logic [15:0] halfMask;
  tpl_count_t wrHalf [3];
  logic carrierRun;
  logic carrierUf;
  logic ufTrig, stopWrTrig, swTrig;
  logic transfer;
  logic [2:0] phEn, phTrigOk, phPulse, phFall;
  logic dtDisable;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // writes land on the edge where the master sees ack
  assign wrEn = cyc_i && stb_i && we_i && ack_o;
  assign halfMask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  for (genvar p = 0; p < 3; p++) begin : g_wrhalf
    assign wrHalf[p] = (phWidth_reg[p] & ~halfMask)
                       | (dat_i[15:0] & halfMask);
  end

  // one wait state: ack one edge after the request, dropped right after
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_o <= 1'b0;
      dat_o <= `TPL_RST_WORD;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= (cyc_i && stb_i && !ack_o && !we_i) ? rdData_next
                                                  : `TPL_RST_WORD;
    end
  end

  // read mux; unmapped offsets answer zero
  always_comb begin
    rdData_next = `TPL_RST_WORD;
    case (adr_i)
      `TPL_ADR_START: rdData_next[7:0] = countStart_reg;
      `TPL_ADR_INVC_FIRST: rdData_next[6:0] = invFirst_reg[6:0];
      `TPL_ADR_INVC_SECOND: rdData_next[7:0] = invSecond_reg;
      `TPL_ADR_BUF_FIRST: rdData_next[5:0] = levelBufFirst_reg;
      `TPL_ADR_BUF_SECOND: rdData_next[5:0] = levelBufSecond_reg;
      `TPL_ADR_CARRIER: rdData_next[15:0] = carrierReload_reg;
      `TPL_ADR_WIDTH_U: rdData_next[15:0] = phWidth_reg[0];
      `TPL_ADR_WIDTH_V: rdData_next[15:0] = phWidth_reg[1];
      `TPL_ADR_WIDTH_W: rdData_next[15:0] = phWidth_reg[2];
      `TPL_ADR_DEAD: rdData_next[7:0] = deadTime_reg;
      `TPL_ADR_STATUS: rdData_next = {carrierCnt_reg, 2'b00,
        wroteSecond_reg, wroteFirst_reg, selSecond_reg, phPulse,
        internal_reg};
      `TPL_ADR_PH_MODE: rdData_next[7:0] = phMode_reg;
      `TPL_ADR_CAR_MODE: rdData_next[7:0] = carMode_reg;
      `TPL_ADR_TRIG_SEL: rdData_next[7:0] = trigSel_reg;
      default: rdData_next = `TPL_RST_WORD;
    endcase
  end

  // software-written registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      countStart_reg <= `TPL_RST_BYTE;
      invFirst_reg <= `TPL_RST_BYTE;
      invSecond_reg <= `TPL_RST_BYTE;
      levelBufFirst_reg <= `TPL_RST_LEVEL;
      levelBufSecond_reg <= `TPL_RST_LEVEL;
      carrierReload_reg <= `TPL_RST_HALF;
      phWidth_reg[0] <= `TPL_RST_HALF;
      phWidth_reg[1] <= `TPL_RST_HALF;
      phWidth_reg[2] <= `TPL_RST_HALF;
      deadTime_reg <= `TPL_RST_DEAD;
      phMode_reg <= `TPL_RST_BYTE;
      carMode_reg <= `TPL_RST_BYTE;
      trigSel_reg <= `TPL_RST_BYTE;
    end else if (wrEn && sel_i[0]) begin
      case (adr_i)
        `TPL_ADR_START: countStart_reg <= dat_i[7:0];
        `TPL_ADR_INVC_FIRST: invFirst_reg <= {1'b0, dat_i[6:0]};
        `TPL_ADR_INVC_SECOND: invSecond_reg <= dat_i[7:0];
        `TPL_ADR_BUF_FIRST: levelBufFirst_reg <= dat_i[5:0];
        `TPL_ADR_BUF_SECOND: levelBufSecond_reg <= dat_i[5:0];
        `TPL_ADR_CARRIER: carrierReload_reg <= (carrierReload_reg & ~halfMask)
                          | (dat_i[15:0] & halfMask);
        `TPL_ADR_WIDTH_U: phWidth_reg[0] <= wrHalf[0];
        `TPL_ADR_WIDTH_V: phWidth_reg[1] <= wrHalf[1];
        `TPL_ADR_WIDTH_W: phWidth_reg[2] <= wrHalf[2];
        `TPL_ADR_DEAD: deadTime_reg <= dat_i[7:0];
        `TPL_ADR_PH_MODE: phMode_reg <= dat_i[7:0];
        `TPL_ADR_CAR_MODE: carMode_reg <= dat_i[7:0];
        `TPL_ADR_TRIG_SEL: trigSel_reg <= dat_i[7:0];
        default: countStart_reg <= countStart_reg;
      endcase
    end else if (wrEn && sel_i[1]) begin
      // upper byte of the 16-bit timer values alone
      case (adr_i)
        `TPL_ADR_CARRIER: carrierReload_reg[15:8] <= dat_i[15:8];
        `TPL_ADR_WIDTH_U: phWidth_reg[0] <= wrHalf[0];
        `TPL_ADR_WIDTH_V: phWidth_reg[1] <= wrHalf[1];
        `TPL_ADR_WIDTH_W: phWidth_reg[2] <= wrHalf[2];
        default: countStart_reg <= countStart_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // carrier timer and transfer triggers
  // ----------------------------------------------------------------
  assign carrierRun = countStart_reg[`TPL_BIT_CAR_START]
                      && !invSecond_reg[`TPL_BIT_CAR_STOP];
  assign carrierUf = carrierRun && carrierCnt_reg == `TPL_RST_HALF;
  assign ufTrig = carrierUf && wroteFirst_reg && wroteSecond_reg;
  assign stopWrTrig = wrEn && sel_i[0] && adr_i == `TPL_ADR_CARRIER
                      && invSecond_reg[`TPL_BIT_CAR_STOP];
  assign swTrig = wrEn && sel_i[0] && adr_i == `TPL_ADR_INVC_FIRST
                  && dat_i[`TPL_BIT_SW_TRANSFER];
  assign transfer = ufTrig || stopWrTrig || swTrig;
  assign dtDisable = invSecond_reg[`TPL_BIT_DT_DISABLE];

  // carrier counts down and reloads at underflow
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      carrierCnt_reg <= `TPL_RST_HALF;
    end else if (!carrierRun) begin
      carrierCnt_reg <= carrierReload_reg;
    end else if (carrierUf) begin
      carrierCnt_reg <= carrierReload_reg;
    end else begin
      carrierCnt_reg <= carrierCnt_reg - `TPL_HALF_ONE;
    end
  end

  // buffer-written flags; a write in the consuming cycle is kept
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wroteFirst_reg <= 1'b0;
      wroteSecond_reg <= 1'b0;
    end else begin
      wroteFirst_reg <= (wrEn && sel_i[0] && adr_i == `TPL_ADR_BUF_FIRST)
                        || (wroteFirst_reg && !transfer);
      wroteSecond_reg <= (wrEn && sel_i[0] && adr_i == `TPL_ADR_BUF_SECOND)
                         || (wroteSecond_reg && !transfer);
    end
  end

  // ----------------------------------------------------------------
  // phase one-shots, started together at carrier underflow
  // ----------------------------------------------------------------
  assign phEn[0] = countStart_reg[`TPL_BIT_U_START];
  assign phEn[1] = countStart_reg[`TPL_BIT_V_START];
  assign phEn[2] = countStart_reg[`TPL_BIT_W_START];
  assign phTrigOk[0] = trigSel_reg[`TPL_TRG_U_LSB +: 2] == `TPL_TRG_ONESHOT;
  assign phTrigOk[1] = trigSel_reg[`TPL_TRG_V_LSB +: 2] == `TPL_TRG_ONESHOT;
  assign phTrigOk[2] = trigSel_reg[`TPL_TRG_W_LSB +: 2] == `TPL_TRG_ONESHOT;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    tpl_oneshot u_oneshot (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .startPulse(carrierUf && phTrigOk[p]),
      .runEn(phEn[p]),
      .widthVal(phWidth_reg[p]),
      .pulseOut(phPulse[p]),
      .fallPulse(phFall[p])
    );

    // transfer wins over a falling edge in the same cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        selSecond_reg[p] <= 1'b0;
        internal_reg[p] <= 1'b0;
        internal_reg[p+3] <= 1'b0;
      end else if (transfer) begin
        selSecond_reg[p] <= 1'b0;
        internal_reg[p] <= levelBufFirst_reg[p];
        internal_reg[p+3] <= levelBufFirst_reg[p+3];
      end else if (phFall[p]) begin
        selSecond_reg[p] <= !selSecond_reg[p];
        internal_reg[p] <= selSecond_reg[p] ? stageFirst_reg[p]
                                            : stageSecond_reg[p];
        internal_reg[p+3] <= selSecond_reg[p] ? stageFirst_reg[p+3]
                                              : stageSecond_reg[p+3];
      end
    end

    started_a: assert property (
      carrierUf && phTrigOk[p] && phEn[p] && phWidth_reg[p] != `TPL_RST_HALF
      |=> phPulse[p])
      else $error("phase one-shot did not start on trigger");
    alternate_a: assert property (
      phFall[p] && !transfer |=> selSecond_reg[p] != $past(selSecond_reg[p])
        && internal_reg[p] == ($past(selSecond_reg[p])
          ? stageFirst_reg[p] : stageSecond_reg[p]))
      else $error("phase level did not alternate at pulse fall");
  end

  // shift registers change only on a transfer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stageFirst_reg <= `TPL_RST_LEVEL;
      stageSecond_reg <= `TPL_RST_LEVEL;
    end else if (transfer) begin
      stageFirst_reg <= levelBufFirst_reg;
      stageSecond_reg <= levelBufSecond_reg;
    end
  end

  // ----------------------------------------------------------------
  // dead time per output
  // ----------------------------------------------------------------
  // one cycle behind the internal level, so turn-off edges stay aligned
  for (genvar b = 0; b < 6; b++) begin : g_dead
    tpl_byte_t deadCnt_reg;
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        deadCnt_reg <= `TPL_RST_DEAD;
        pwmOut[b] <= 1'b0;
      end else if (dtDisable || !internal_reg[b]) begin
        // turn-off, or no dead time: follow the internal level
        deadCnt_reg <= deadTime_reg;
        pwmOut[b] <= internal_reg[b];
      end else if (deadCnt_reg == `TPL_RST_BYTE) begin
        pwmOut[b] <= 1'b1;
      end else begin
        deadCnt_reg <= deadCnt_reg - `TPL_BYTE_ONE;
      end
    end

    fast_off_a: assert property (
      !internal_reg[b] |=> !pwmOut[b])
      else $error("output stayed active after internal fell");
    dead_wait_a: assert property (
      !dtDisable && $rose(pwmOut[b]) |-> $past(deadCnt_reg) == 8'h00
        && $past(internal_reg[b]))
      else $error("output went active before dead time ended");
  end

  // ----------------------------------------------------------------
  // assertions on triggers and transfer
  // ----------------------------------------------------------------
  sequence bothWritten;
    wroteFirst_reg && wroteSecond_reg;
  endsequence

  sequence transferThenHold;
    transfer ##1 !transfer && !phFall[0];
  endsequence

  uf_transfer_a: assert property (
    bothWritten ##0 carrierUf
    |=> stageFirst_reg == $past(levelBufFirst_reg)
      && stageSecond_reg == $past(levelBufSecond_reg))
    else $error("underflow with both buffers written did not transfer");
  stop_write_a: assert property (
    wrEn && sel_i[0] && adr_i == 8'h14 && invSecond_reg[0]
    |=> stageFirst_reg == $past(levelBufFirst_reg))
    else $error("carrier write while stopped did not transfer");
  sw_trigger_a: assert property (
    wrEn && sel_i[0] && adr_i == 8'h04 && dat_i[7]
    |=> stageSecond_reg == $past(levelBufSecond_reg))
    else $error("software transfer bit did not transfer");
  copy_first_a: assert property (
    transferThenHold |-> internal_reg[0] == stageFirst_reg[0]
      && !selSecond_reg[0])
    else $error("phase did not take first buffer after transfer");
  hold_shift_a: assert property (
    !transfer |=> $stable(stageFirst_reg) && $stable(stageSecond_reg))
    else $error("shift registers changed without a transfer");
endmodule : tpl_pwm_top
`default_nettype wire

// ---- sim/three_phase_pwm_output_level_ctrl_tb.sv ----
// Purpose: self-checking bench of the three-phase level block
// Assumes: classic Wishbone, one ack per request, mclk 4 ns
// Notes: latencies compared as differences, so fixed pipe depth cancels
`timescale 1ns/1ps
`default_nettype none
`include "tpl_cfg.svh"

module three_phase_pwm_output_level_ctrl_tb;
  import tpl_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cycI = 1'b0;
  logic stbI = 1'b0;
  logic weI = 1'b0;
  tpl_byte_t adrI = 8'h00;
  logic [31:0] datI = 32'h00000000;
  logic [3:0] selI = 4'h0;
  logic [31:0] datO;
  logic ackO;
  tpl_level_t pwmOut;
  int chgCnt [3];
  int chgTime [3];
  int prevTime [3];
  int kb [3];
  int error_cnt = 0;
  int cmp_count = 0;
  int t0;
  int lat0;
  int k;
  logic [31:0] rd;
  tpl_level_t mA;
  tpl_level_t mB;
  tpl_level_t mInt;

  tpl_pwm_top tpl_pwm_top_i (.mclk(mclk), .sys_rst(sys_rst), .cyc_i(cycI),
    .stb_i(stbI), .we_i(weI), .adr_i(adrI), .dat_i(datI), .sel_i(selI),
    .dat_o(datO), .ack_o(ackO), .pwmOut(pwmOut));
  tpl_gate_model tpl_gate_model_i (.mclk(mclk), .sys_rst(sys_rst),
    .pwmOut(pwmOut), .chgCnt(chgCnt), .chgTime(chgTime),
    .prevTime(prevTime));

  // ----------------------------------------------------------------
  // clock, bus and compare tasks
  // ----------------------------------------------------------------
  initial begin
    forever #2 mclk = ~mclk;
  end

  // request held until ack is sampled; t0 marks the ack edge
  // a slave that never answers is caught by the watchdog
  task automatic wb(input logic w, input tpl_byte_t a, input logic [31:0] d);
    cycI <= 1'b1;
    stbI <= 1'b1;
    weI <= w;
    adrI <= a;
    datI <= d;
    selI <= 4'hf;
    do begin
      @(posedge mclk);
    end while (ackO !== 1'b1);
    rd = datO;
    t0 = int'($time);
    cycI <= 1'b0;
    stbI <= 1'b0;
    @(posedge mclk);
  endtask : wb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic rc(input tpl_byte_t a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rc

  // internal phase levels seen through the status word
  task automatic lv(input tpl_level_t exp);
    wb(1'b0, `TPL_ADR_STATUS, 32'h0);
    chk({26'h0, rd[5:0]}, {26'h0, exp});
  endtask : lv

  // software transfer of a new first level
  task automatic sw(input tpl_level_t f);
    wb(1'b1, `TPL_ADR_BUF_FIRST, {26'h0, f});
    wb(1'b1, `TPL_ADR_INVC_FIRST, 32'h80);
    repeat (20) @(posedge mclk);
  endtask : sw

  task automatic finish_test();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  // whole run is about a thousand cycles
  initial begin
    #60000;
    error_cnt++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(98819));
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    // reset values, unmapped place, quiet outputs
    rc(`TPL_ADR_DEAD, 32'h1);
    rc(`TPL_ADR_CARRIER, 32'h0);
    rc(8'h3c, 32'h0);
    wb(1'b1, `TPL_ADR_BUF_FIRST, 32'h3f);
    wb(1'b1, `TPL_ADR_BUF_SECOND, 32'h2a);
    repeat (20) @(posedge mclk);
    chk(pwmOut, 32'h0);
    lv(6'h00);
    chk(rd[13:12], 2'h3);
    // dead time off gives the reference latency
    wb(1'b1, `TPL_ADR_INVC_SECOND, 32'h20);
    sw(6'h01);
    lat0 = chgTime[0] - t0;
    chk(pwmOut, 32'h01);
    wb(1'b1, `TPL_ADR_INVC_SECOND, 32'h0);
    wb(1'b1, `TPL_ADR_DEAD, 32'h5);
    sw(6'h00);
    chk(chgTime[0] - t0, lat0);
    sw(6'h01);
    chk(chgTime[0] - t0, lat0 + 20);
    wb(1'b1, `TPL_ADR_INVC_SECOND, 32'h20);
    // software setup of the timers, stored as plain registers
    wb(1'b1, `TPL_ADR_PH_MODE, 32'h12);
    rc(`TPL_ADR_PH_MODE, 32'h12);
    wb(1'b1, `TPL_ADR_CAR_MODE, 32'h00);
    // random complementary levels, software transfer
    mA = 6'($urandom);
    mB = ~mA;
    wb(1'b1, `TPL_ADR_BUF_FIRST, {26'h0, mA});
    wb(1'b1, `TPL_ADR_BUF_SECOND, {26'h0, mB});
    wb(1'b1, `TPL_ADR_INVC_FIRST, 32'h95);
    mInt = mA;
    lv(mInt);
    rc(`TPL_ADR_INVC_FIRST, 32'h15);
    // three one-shots from one carrier, period 100 cycles
    wb(1'b1, `TPL_ADR_WIDTH_U, 32'd20);
    wb(1'b1, `TPL_ADR_WIDTH_V, 32'd13);
    wb(1'b1, `TPL_ADR_WIDTH_W, 32'd31);
    wb(1'b1, `TPL_ADR_TRIG_SEL, 32'h45);
    wb(1'b1, `TPL_ADR_CARRIER, 32'd99);
    kb = chgCnt;
    wb(1'b1, `TPL_ADR_START, 32'h96);
    repeat (350) @(posedge mclk);
    wb(1'b1, `TPL_ADR_START, 32'h00);
    k = chgCnt[0] - kb[0];
    mInt = k[0] ? mB : mA;
    lv(mInt);
    chk(pwmOut, {26'h0, mInt});
    chk(k >= 3, 32'h1);
    chk(chgCnt[1] - kb[1], k);
    chk(chgCnt[2] - kb[2], k);
    chk(chgTime[0] - chgTime[1], 28);
    chk(chgTime[2] - chgTime[0], 44);
    chk(chgTime[0] - prevTime[0], 400);
    // underflow transfer needs both buffers written
    wb(1'b1, `TPL_ADR_TRIG_SEL, 32'h00);
    mA = mInt ^ 6'(1 + $urandom % 63);
    wb(1'b1, `TPL_ADR_BUF_FIRST, {26'h0, mA});
    wb(1'b1, `TPL_ADR_START, 32'h80);
    repeat (250) @(posedge mclk);
    lv(mInt);
    wb(1'b1, `TPL_ADR_BUF_SECOND, {26'h0, 6'($urandom)});
    repeat (250) @(posedge mclk);
    mInt = mA;
    lv(mInt);
    wb(1'b1, `TPL_ADR_START, 32'h00);
    // reload write transfers only while the stop bit is set
    mA = mInt ^ 6'(1 + $urandom % 63);
    wb(1'b1, `TPL_ADR_BUF_FIRST, {26'h0, mA});
    wb(1'b1, `TPL_ADR_CARRIER, 32'd50);
    lv(mInt);
    wb(1'b1, `TPL_ADR_INVC_SECOND, 32'h21);
    wb(1'b1, `TPL_ADR_CARRIER, 32'd50);
    mInt = mA;
    lv(mInt);
    // whole status word: stopped carrier shows its reload, flags cleared
    rc(`TPL_ADR_STATUS, {16'h0032, 10'h000, mA});
    finish_test();
  end
endmodule : three_phase_pwm_output_level_ctrl_tb

`default_nettype wire

// ---- sim/tpl_gate_model.sv ----
// Purpose: gate driver side, logs when each phase leg pair changes
// Assumes: pwmOut bits 0..2 upper, bits 3..5 lower arms of U,V,W
// Notes: passive load, the drivers never push back on the block
`timescale 1ns/1ps
`default_nettype none

module tpl_gate_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // gate inputs
  input wire tpl_pkg::tpl_level_t pwmOut,
  // change log per phase
  output var int chgCnt [3],
  output var int chgTime [3],
  output var int prevTime [3]
);
  import tpl_pkg::*;
  tpl_level_t lastPwm_reg;
  // ----------------------------------------------------------------
  // change log
  // ----------------------------------------------------------------
  // times kept in ns so the bench can difference them directly
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lastPwm_reg <= 6'h00;
      chgCnt <= '{0, 0, 0};
      chgTime <= '{0, 0, 0};
      prevTime <= '{0, 0, 0};
    end else begin
      lastPwm_reg <= pwmOut;
      for (int i = 0; i < 3; i++) begin
        if ({pwmOut[i+3], pwmOut[i]}
            != {lastPwm_reg[i+3], lastPwm_reg[i]}) begin
          chgCnt[i] <= chgCnt[i] + 1;
          prevTime[i] <= chgTime[i];
          chgTime[i] <= int'($time);
        end
      end
    end
  end
endmodule : tpl_gate_model

`default_nettype wire
